// file: include/lin_ctl_pkg.sv
// Shared offsets, field positions, reset values and carriers of the LIN serial control block
package lin_ctl_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_EXT    = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_BAUD   = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hc;
  // Control register bit positions
  localparam int unsigned B_TXEN = 0;
  localparam int unsigned B_RXEN = 1;
  localparam int unsigned B_MODE = 2;
  localparam int unsigned B_SRST = 4;
  localparam int unsigned B_SAMPLE_EDGE_SELECT = 5;
  localparam int unsigned B_CCO  = 6;
  localparam int unsigned B_TIE  = 7;
  localparam int unsigned B_BLEN = 8;
  // Extended communication control bit positions
  localparam int unsigned B_TBI  = 0;
  localparam int unsigned B_RBI  = 1;
  localparam int unsigned B_SSM  = 3;
  localparam int unsigned B_CLOCK_DELAY_ENABLE = 4;
  localparam int unsigned B_SIDE = 5;
  localparam int unsigned B_BRK  = 6;
  localparam int unsigned B_BDET = 8;
  // Baud reload layout
  localparam int unsigned RELOAD_W = 15;
  localparam logic [RELOAD_W-1:0] RELOAD_RST = 15'h0000;
  // Operating modes and break timing in bit times
  localparam logic [1:0] MODE_SYNC = 2'h2;
  localparam logic [1:0] MODE_LIN  = 2'h3;
  localparam logic [4:0] BRK_BASE_BITS = 5'h0d;
  localparam logic [4:0] BRK_DET_BITS  = 5'h0b;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic       tx_irq_enable;
    logic       continuous_clock_enable;
    logic       sample_edge_select;
    logic [1:0] operating_mode_select;
    logic       rx_enable;
    logic       tx_enable;
    logic [1:0] break_length_select;
  } ctrl_t;
  typedef struct packed {
    logic clock_side_select;
    logic clock_delay_enable;
    logic start_stop_mode;
  } ext_t;
  localparam ctrl_t CTRL_RST = '0;
  localparam ext_t  EXT_RST  = '0;
endpackage

// file: logic/baud_reload_gen.sv
// Down-counting baud reload generator with full and half period ticks
module baud_reload_gen #(
  parameter int unsigned W = 15
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Control
  input  wire logic         restart,
  input  wire logic [W-1:0] reload,
  // Outputs
  output logic [W-1:0]      count,
  output logic              tick,
  output logic              half_tick
);
  logic [W-1:0] cnt_q, cnt_d;
  logic         tick_q, tick_d, half_q, half_d;

  // Count down, reload at zero; a write restarts from the new value
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    half_d = 1'b0;
    if (restart) begin
      cnt_d = reload;
    end else if (cnt_q == '0) begin
      cnt_d  = reload;
      tick_d = 1'b1;
    end else begin
      cnt_d  = cnt_q - W'(1);
      half_d = (cnt_q == (reload >> 1));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
      half_q <= half_d;
    end
  end

  assign count     = cnt_q;
  assign tick      = tick_q;
  assign half_tick = half_q;
endmodule

// file: logic/lin_break_unit.sv
// LIN break generator and fixed-length break detector, counted in bit ticks
module lin_break_unit
  import lin_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Timing and control
  input  wire logic       bit_tick,
  input  wire logic       clear,
  input  wire logic       start,
  input  wire logic [1:0] len_sel,
  input  wire logic       detect_en,
  input  wire logic       sin_level,
  // Results
  output logic            breaking,
  output logic            detected
);
  logic [4:0] gen_q, gen_d, det_q, det_d;
  logic       act_q, act_d, hit_q, hit_d;
  logic [4:0] target;

  // Break length 13..16 bit times from the select code
  assign target = BRK_BASE_BITS + {3'h0, len_sel};

  always_comb begin
    gen_d = gen_q;
    act_d = act_q;
    det_d = det_q;
    hit_d = 1'b0;
    // Generation: hold the line low for the selected bit count
    if (clear) begin
      act_d = 1'b0;
      gen_d = '0;
    end else if (start && !act_q) begin
      act_d = 1'b1;
      gen_d = '0;
    end else if (act_q && bit_tick) begin
      gen_d = gen_q + 5'h01;
      if (gen_q + 5'h01 == target) begin
        act_d = 1'b0;
      end
    end
    // Detection always uses eleven low bit times, independent of the select
    if (clear || !detect_en || sin_level) begin
      det_d = '0;
    end else if (bit_tick && det_q != BRK_DET_BITS) begin
      det_d = det_q + 5'h01;
      hit_d = (det_q + 5'h01 == BRK_DET_BITS);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_q <= '0;
      act_q <= 1'b0;
      det_q <= '0;
      hit_q <= 1'b0;
    end else begin
      gen_q <= gen_d;
      act_q <= act_d;
      det_q <= det_d;
      hit_q <= hit_d;
    end
  end

  assign breaking = act_q;
  assign detected = hit_q;
endmodule

// file: logic/lin_uart_ext_ctl.sv
// LIN serial unit control: AXI4-Lite registers, baud generator, break and clock pins
//
// Contract
// - In LIN mode a written break_generate one sends a break; reads zero.
// - In mode 2 clock_side_select zero drives the clock, one takes external clock.
// - Mode 2 driving side with clock_delay_enable outputs a delayed clock.
// - Mode 2 start_stop_mode frames data with start/stop; reads zero elsewhere.
// - rx_idle_flag is one when input high and no reception; read-only.
// - tx_idle_flag is one when no transmission active; read-only.
// - 15-bit reload, high seven and low eight bits; reads give live count.
// - Writing reload restarts counting; byte and word writes both accepted.
// - tx_enable and rx_enable reset to zero; software sets and clears them.
// - tx_empty_flag resets to one, so enabling the irq raises it at once.
// - Break length selectable; receive detection fixed at eleven low bit times.
// - Break length codes 0..3 give 13, 14, 15, 16 bit times.
// - LIN mode uses eight data bits, no parity, one stop, LSB first.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
module lin_uart_ext_ctl
  import lin_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite write
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [lin_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  output logic [1:0]                    s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  input  wire logic [lin_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  // Line pins
  input  wire logic                     serial_in_pin,
  output logic                          serial_out_pin,
  input  wire logic                     sck_in,
  output logic                          sck_out,
  output logic                          sck_oe,
  // Frame engine side
  input  wire logic                     frame_tx_busy,
  input  wire logic                     frame_rx_busy,
  input  wire logic                     frame_sout,
  input  wire logic                     tx_data_load,
  input  wire logic                     tx_data_taken,
  output lin_ctl_pkg::ctrl_t            cfg_ctrl,
  output lin_ctl_pkg::ext_t             cfg_ext,
  output logic                          bit_tick,
  output logic                          sample_strobe,
  output logic                          soft_reset_pulse,
  output logic                          tx_irq
);
  import lin_ctl_pkg::*;

  // Register state and bus state
  ctrl_t                ctrl_q, ctrl_d;
  ext_t                 ext_q, ext_d;
  logic [RELOAD_W-1:0]  reload_q, reload_d;
  logic                 bdet_q, bdet_d, tx_empty_flag_q, tx_empty_flag_d;
  logic                 aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [ADDR_W-1:0]    awa_q, awa_d;
  logic [31:0]          wd_q, wd_d, rd_q, rd_d;
  logic [3:0]           ws_q, ws_d;
  logic [1:0]           br_q, br_d, rr_q, rr_d;
  logic                 srst_q, srst_d, brk_q, brk_d, load_q, load_d;
  // Line-side state
  logic                 sin_s1_q, sin_s2_q, sck_s1_q, sck_s2_q, sck_s3_q;
  logic                 sck_gen_q, sck_gen_d, sck_del_q, sck_del_d;
  logic                 sck_o_q, sck_o_d, oe_q, oe_d, sout_q, sout_d;
  logic                 strobe_q, strobe_d, irq_q, irq_d;
  // Derived
  logic                 mode2, mode3, side_eff, delay_eff, ssm_eff;
  logic                 do_wr, tick, half_tick, breaking, detected;
  logic                 tx_idle, rx_idle;
  logic [RELOAD_W-1:0]  live_count;
  logic [31:0]          rmux;
  logic                 rok;

  // Mode-2 only bits are stored but act and read as zero elsewhere
  assign mode2     = (ctrl_q.operating_mode_select == MODE_SYNC);
  assign mode3     = (ctrl_q.operating_mode_select == MODE_LIN);
  assign side_eff  = ext_q.clock_side_select & mode2;
  assign delay_eff = ext_q.clock_delay_enable & mode2;
  assign ssm_eff   = ext_q.start_stop_mode & mode2;
  assign tx_idle   = !(frame_tx_busy || breaking);
  assign rx_idle   = sin_s2_q && !frame_rx_busy;
  assign do_wr     = aw_q && w_q && !b_q;

  baud_reload_gen #(
    .W (RELOAD_W)
  ) u_baud (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .restart   (load_q || srst_q),
    .reload    (reload_q),
    .count     (live_count),
    .tick      (tick),
    .half_tick (half_tick)
  );

  lin_break_unit u_break (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .bit_tick  (tick),
    .clear     (srst_q),
    .start     (brk_q),
    .len_sel   (ctrl_q.break_length_select),
    .detect_en (mode3),
    .sin_level (sin_s2_q),
    .breaking  (breaking),
    .detected  (detected)
  );

  // Read multiplexer; unmapped offsets answer an error with zero data
  always_comb begin
    rmux = '0;
    rok  = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL: begin
        rmux[B_TXEN]          = ctrl_q.tx_enable;
        rmux[B_RXEN]          = ctrl_q.rx_enable;
        rmux[B_MODE +: 2]     = ctrl_q.operating_mode_select;
        rmux[B_SAMPLE_EDGE_SELECT]          = ctrl_q.sample_edge_select;
        rmux[B_CCO]           = ctrl_q.continuous_clock_enable;
        rmux[B_TIE]           = ctrl_q.tx_irq_enable;
        rmux[B_BLEN +: 2]     = ctrl_q.break_length_select;
      end
      OFF_EXT: begin
        rmux[B_TBI]  = tx_idle;
        rmux[B_RBI]  = rx_idle;
        rmux[B_SSM]  = ssm_eff;
        rmux[B_CLOCK_DELAY_ENABLE] = delay_eff;
        rmux[B_SIDE] = side_eff;
        rmux[B_BDET] = bdet_q;
      end
      OFF_BAUD: rmux[RELOAD_W-1:0] = live_count;
      OFF_STATUS: begin
        rmux[0] = tx_empty_flag_q;
        rmux[1] = irq_q;
        rmux[2] = breaking;
      end
      default: rok = 1'b0;
    endcase
  end

  // Bus handshakes: address and data held independently, then one write
  always_comb begin
    aw_d  = aw_q;
    awa_d = awa_q;
    w_d   = w_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    b_d   = b_q;
    br_d  = br_q;
    r_d   = r_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = (awa_q == OFF_CTRL || awa_q == OFF_EXT || awa_q == OFF_BAUD ||
              awa_q == OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_d  = 1'b1;
      rd_d = rmux;
      rr_d = rok ? RESP_OKAY : RESP_SLVERR;
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  // Register writes and the pulses they raise
  always_comb begin
    ctrl_d   = ctrl_q;
    ext_d    = ext_q;
    reload_d = reload_q;
    srst_d   = 1'b0;
    brk_d    = 1'b0;
    load_d   = 1'b0;
    bdet_d   = bdet_q;
    tx_empty_flag_d   = tx_empty_flag_q;
    if (do_wr && awa_q == OFF_CTRL) begin
      if (ws_q[0]) begin
        ctrl_d.tx_enable               = wd_q[B_TXEN];
        ctrl_d.rx_enable               = wd_q[B_RXEN];
        ctrl_d.operating_mode_select   = wd_q[B_MODE +: 2];
        ctrl_d.sample_edge_select      = wd_q[B_SAMPLE_EDGE_SELECT];
        ctrl_d.continuous_clock_enable = wd_q[B_CCO];
        ctrl_d.tx_irq_enable           = wd_q[B_TIE];
        // Soft reset refused while the inverted sample edge is in force
        // Also refused when the same write sets the edge select
        srst_d = wd_q[B_SRST] && !ctrl_q.sample_edge_select && !wd_q[B_SAMPLE_EDGE_SELECT];
      end
      if (ws_q[1]) begin
        ctrl_d.break_length_select = wd_q[B_BLEN +: 2];
      end
    end
    if (do_wr && awa_q == OFF_EXT) begin
      if (ws_q[0]) begin
        // Reserved bits 7 and 2 are dropped; break_generate is a trigger only
        ext_d.clock_side_select  = wd_q[B_SIDE];
        ext_d.clock_delay_enable = wd_q[B_CLOCK_DELAY_ENABLE];
        ext_d.start_stop_mode    = wd_q[B_SSM];
        brk_d = wd_q[B_BRK] && mode3;
      end
      if (ws_q[1] && !wd_q[B_BDET]) begin
        bdet_d = 1'b0;
      end
    end
    if (do_wr && awa_q == OFF_BAUD) begin
      if (ws_q[1]) begin
        reload_d[RELOAD_W-1:8] = wd_q[RELOAD_W-1:8];
      end
      if (ws_q[0]) begin
        reload_d[7:0] = wd_q[7:0];
      end
      load_d = ws_q[0] || ws_q[1];
    end
    // Hardware set beats the software clear in the same cycle
    if (detected) begin
      bdet_d = 1'b1;
    end
    if (tx_data_load) begin
      tx_empty_flag_d = 1'b0;
    end
    if (tx_data_taken || srst_q) begin
      tx_empty_flag_d = 1'b1;
    end
  end

  // Line side: clock generation, sampling strobe, serial output, irq
  always_comb begin
    sck_gen_d = sck_gen_q;
    sck_del_d = sck_del_q;
    if (!mode2 || side_eff || !(frame_tx_busy || ctrl_q.continuous_clock_enable)) begin
      sck_gen_d = 1'b0;
      sck_del_d = 1'b0;
    end else begin
      // Undelayed clock rises mid-period; delayed copy trails by half a period
      if (half_tick) begin
        sck_gen_d = 1'b1;
        sck_del_d = 1'b0;
      end
      if (tick) begin
        sck_gen_d = 1'b0;
        sck_del_d = 1'b1;
      end
    end
    sck_o_d = (delay_eff ? sck_del_q : sck_gen_q) ^ ctrl_q.sample_edge_select;
    oe_d    = mode2 && !side_eff;
    // External clock sampled on the selected edge when on the receiving side
    strobe_d = side_eff && (ctrl_q.sample_edge_select ? (sck_s3_q && !sck_s2_q)
                                                      : (!sck_s3_q && sck_s2_q));
    sout_d = breaking ? 1'b0 : frame_sout;
    irq_d  = ctrl_q.tx_irq_enable && tx_empty_flag_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= CTRL_RST;
      ext_q    <= EXT_RST;
      reload_q <= RELOAD_RST;
      bdet_q   <= 1'b0;
      tx_empty_flag_q   <= 1'b1;
      srst_q   <= 1'b0;
      brk_q    <= 1'b0;
      load_q   <= 1'b0;
      aw_q     <= 1'b0;
      awa_q    <= '0;
      w_q      <= 1'b0;
      wd_q     <= '0;
      ws_q     <= '0;
      b_q      <= 1'b0;
      br_q     <= RESP_OKAY;
      r_q      <= 1'b0;
      rd_q     <= '0;
      rr_q     <= RESP_OKAY;
      sin_s1_q <= 1'b1;
      sin_s2_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      sck_gen_q <= 1'b0;
      sck_del_q <= 1'b0;
      sck_o_q  <= 1'b0;
      oe_q     <= 1'b0;
      strobe_q <= 1'b0;
      sout_q   <= 1'b1;
      irq_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      ext_q    <= ext_d;
      reload_q <= reload_d;
      bdet_q   <= bdet_d;
      tx_empty_flag_q   <= tx_empty_flag_d;
      srst_q   <= srst_d;
      brk_q    <= brk_d;
      load_q   <= load_d;
      aw_q     <= aw_d;
      awa_q    <= awa_d;
      w_q      <= w_d;
      wd_q     <= wd_d;
      ws_q     <= ws_d;
      b_q      <= b_d;
      br_q     <= br_d;
      r_q      <= r_d;
      rd_q     <= rd_d;
      rr_q     <= rr_d;
      sin_s1_q <= serial_in_pin;
      sin_s2_q <= sin_s1_q;
      sck_s1_q <= sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      sck_gen_q <= sck_gen_d;
      sck_del_q <= sck_del_d;
      sck_o_q  <= sck_o_d;
      oe_q     <= oe_d;
      strobe_q <= strobe_d;
      sout_q   <= sout_d;
      irq_q    <= irq_d;
    end
  end

  // Ready only while nothing of the same kind is held or answered
  assign s_axi_awready    = !aw_q && !b_q;
  assign s_axi_wready     = !w_q && !b_q;
  assign s_axi_bvalid     = b_q;
  assign s_axi_bresp      = br_q;
  assign s_axi_arready    = !r_q;
  assign s_axi_rvalid     = r_q;
  assign s_axi_rdata      = rd_q;
  assign s_axi_rresp      = rr_q;
  assign serial_out_pin   = sout_q;
  assign sck_out          = sck_o_q;
  assign sck_oe           = oe_q;
  assign cfg_ctrl         = ctrl_q;
  assign cfg_ext          = '{clock_side_select: side_eff, clock_delay_enable: delay_eff,
                              start_stop_mode: ssm_eff};
  assign bit_tick         = tick;
  assign sample_strobe    = strobe_q;
  assign soft_reset_pulse = srst_q;
  assign tx_irq           = irq_q;
endmodule

// file: dv/lin_uart_ext_ctl_assertions.sv
// Port-level assertions of the LIN serial control block
module lin_uart_ext_ctl_assertions
  import lin_ctl_pkg::*;
(
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Line and frame side
  input wire logic                serial_out_pin,
  input wire logic                frame_sout,
  input wire logic                sck_oe,
  input wire logic                sample_strobe,
  input wire logic                soft_reset_pulse,
  input wire logic                tx_irq,
  input wire lin_ctl_pkg::ctrl_t  cfg_ctrl,
  input wire lin_ctl_pkg::ext_t   cfg_ext
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Mode decode; two- and three-cycle antecedents absorb the register lag of the outputs
  wire sync_m = cfg_ctrl.operating_mode_select == MODE_SYNC;
  wire drv_m  = sync_m && !cfg_ext.clock_side_select;

  AST_EN_RST: assert property (
    $rose(aresetn) |-> !cfg_ctrl.tx_enable && !cfg_ctrl.rx_enable)
    else $error("transfer enables set after reset");
  AST_OE_OFF: assert property (
    (!drv_m)[*2] |-> !sck_oe) else $error("clock driven while not driving side");
  AST_OE_ON: assert property (
    drv_m[*2] |-> sck_oe) else $error("clock not driven on driving side");
  AST_EXT_MASK: assert property (
    (!sync_m)[*2] |-> cfg_ext == '0) else $error("sync-only settings live outside mode 2");
  AST_IRQ_OFF: assert property (
    (!cfg_ctrl.tx_irq_enable)[*2] |-> !tx_irq) else $error("tx irq while disabled");
  AST_SOUT: assert property (
    (cfg_ctrl.operating_mode_select != MODE_LIN)[*3] |-> serial_out_pin == $past(frame_sout))
    else $error("serial out differs from frame data outside LIN mode");
  AST_STROBE: assert property (
    sample_strobe |-> sync_m && cfg_ext.clock_side_select)
    else $error("sample strobe outside receiving side");
  AST_SRST_SAMPLE_EDGE_SELECT: assert property (
    soft_reset_pulse |-> !cfg_ctrl.sample_edge_select) else $error("soft reset with edge select");
  AST_SRST_PULSE: assert property (
    soft_reset_pulse |=> !soft_reset_pulse) else $error("soft reset longer than a cycle");
endmodule

// file: dv/lin_line_peer.sv
// Far-side line model: LIN node on the serial input, clock source in receiving mode
module lin_line_peer (
  // Line toward the block
  output logic serial_in_pin,
  output logic sck_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Recessive line and a still clock between frames
  initial begin
    serial_in_pin = 1'b1;
    sck_in = 1'b0;
  end
  // Dominant level for a span, then the pull-up returns the line high
  task automatic drive_low(input int ns);
    serial_in_pin = 1'b0;
    #(ns);
    serial_in_pin = 1'b1;
  endtask
  // External clock with a 125 ns period for one frame only
  task automatic clock_frame(input int n);
    repeat (n) begin
      #62.5 sck_in = 1'b1;
      #62.5 sck_in = 1'b0;
    end
  endtask
endmodule

// file: dv/lin_uart_ext_ctl_tb_top.sv
// Self-checking bench of the LIN serial control block
module lin_uart_ext_ctl_tb_top
  import lin_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, w;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        serial_in_pin, serial_out_pin, sck_in, sck_out, sck_oe;
  logic        frame_tx_busy = 1'b0, frame_rx_busy = 1'b0, frame_sout = 1'b1;
  logic        tx_data_load = 1'b0, tx_data_taken = 1'b0;
  ctrl_t       cfg_ctrl;
  ext_t        cfg_ext;
  logic        bit_tick, sample_strobe, soft_reset_pulse, tx_irq;
  int          n_fail = 0, total_checks = 0, n_srst = 0, n_strb = 0, r, lo;

  lin_uart_ext_ctl i_lin_uart_ext_ctl (.*);
  lin_line_peer peer (.serial_in_pin, .sck_in);

  // Clock, and pulse counters sampled away from the active edge
  always #5 aclk = ~aclk;
  always @(negedge aclk) begin
    n_srst += soft_reset_pulse;
    n_strb += sample_strobe;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic stall;
    n_fail++;
    $display("wrong value bus_wait exp answer got none");
    close_out();
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 40 && !tb; k++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (tb !== 1'b1) stall();
  endtask
  // Read: data captured on the falling edge before the rising edge that completes the handshake
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 40 && !tr; k++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (tr !== 1'b1) stall();
  endtask

  initial begin
    r = $urandom(35);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CTRL, v);
    chk("ctrl_rst", 32'h0, v);
    rd(OFF_EXT, v);
    chk("ext_rst", 32'h3, v);
    rd(OFF_STATUS, v);
    chk("status_rst", 32'h1, v);
    frame_rx_busy <= 1'b1;
    rd(OFF_EXT, v);
    chk("rx_busy", 32'h1, v);
    frame_rx_busy <= 1'b0;
    // Unmapped offsets answer an error and leave nothing behind
    rd(4'h2, v);
    chk("rresp_unmapped", 32'(RESP_SLVERR), 32'(s_axi_rresp));
    chk("rdata_unmapped", 32'h0, v);
    wr(4'h2, 32'hffff, 4'hf);
    chk("bresp_unmapped", 32'(RESP_SLVERR), 32'(s_axi_bresp));
    // Sync-only bits stored in every mode but visible only in mode 2
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, 32'(m) << 2, 4'h1);
      wr(OFF_EXT, 32'h38, 4'h1);
      rd(OFF_EXT, v);
      chk("ext_mode", (m == 2) ? 32'h3b : 32'h3, v);
      wr(OFF_EXT, 32'h0, 4'h1);
    end
    // Random reload, live down-count, upper lane alone
    r = $urandom_range(200, 2);
    wr(OFF_BAUD, 32'h8000 | r, 4'h3);
    chk("bresp_ok", 32'(RESP_OKAY), 32'(s_axi_bresp));
    rd(OFF_BAUD, v);
    chk("baud_top", 32'h0, v & 32'hffff8000);
    chk("baud_range", 32'h1, 32'(v <= r));
    wr(OFF_BAUD, 32'h7f00, 4'h2);
    rd(OFF_BAUD, v);
    rd(OFF_BAUD, w);
    chk("baud_byte", 32'h1, 32'(v[14:8] >= 7'h7e));
    chk("baud_down", 32'h1, 32'(w < v));
    // Eight cycles per bit from here on
    wr(OFF_BAUD, 32'h7, 4'h3);
    for (int s = 0; s < 4; s++) begin
      lo = 0;
      wr(OFF_CTRL, 32'(s) << 8 | 32'hc, 4'h3);
      wr(OFF_EXT, 32'h40, 4'h1);
      fork
        begin
          rd(OFF_EXT, v);
          chk("ext_brk", 32'h2, v);
        end
        repeat (200) @(negedge aclk) lo += !serial_out_pin;
      join
      chk("brk_len", 32'h1, 32'(lo > (12 + s) * 8 && lo <= (13 + s) * 8 + 2));
    end
    // Twelve low bits are a break, nine are not
    fork
      peer.drive_low(960);
      begin
        repeat (30) @(posedge aclk);
        rd(OFF_EXT, v);
        chk("rx_low", 32'h1, v);
      end
    join
    repeat (4) @(posedge aclk);
    rd(OFF_EXT, v);
    chk("brk_det", 32'h103, v);
    wr(OFF_EXT, 32'h0, 4'h2);
    peer.drive_low(720);
    repeat (4) @(posedge aclk);
    rd(OFF_EXT, v);
    chk("brk_short", 32'h3, v);
    // Mode 2: generated clock, then external clock sampling
    wr(OFF_CTRL, 32'h8, 4'h3);
    frame_tx_busy <= 1'b1;
    lo = 0;
    w = 32'h0;
    repeat (64) @(negedge aclk) begin
      lo += sck_out;
      w += 32'(bit_tick);
    end
    chk("tick_rate", 32'h8, w);
    chk("sck_run", 32'h1, 32'(lo > 16 && lo < 48 && sck_oe));
    frame_tx_busy <= 1'b0;
    wr(OFF_EXT, 32'h20, 4'h1);
    lo = n_strb;
    peer.clock_frame(8);
    repeat (8) @(negedge aclk);
    chk("strobes", 32'h8, 32'(n_strb - lo));
    chk("sck_oe_rcv", 32'h0, 32'(sck_oe));
    wr(OFF_EXT, 32'h0, 4'h1);
    // Empty flag raises the irq as soon as it is enabled
    wr(OFF_CTRL, 32'h80, 4'h1);
    @(negedge aclk);
    chk("irq_on", 32'h1, 32'(tx_irq));
    @(posedge aclk);
    tx_data_load <= 1'b1;
    @(posedge aclk);
    tx_data_load <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("irq_load", 32'h0, 32'(tx_irq));
    @(posedge aclk);
    tx_data_taken <= 1'b1;
    @(posedge aclk);
    tx_data_taken <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("irq_taken", 32'h1, 32'(tx_irq));
    // Soft reset refused while the sample edge select is set
    lo = n_srst;
    wr(OFF_CTRL, 32'h10, 4'h1);
    wr(OFF_CTRL, 32'h20, 4'h1);
    wr(OFF_CTRL, 32'h30, 4'h1);
    wr(OFF_CTRL, 32'h0, 4'h1);
    repeat (4) @(negedge aclk);
    chk("srst", 32'h1, 32'(n_srst - lo));
    repeat (20) @(posedge aclk) frame_sout <= 1'($urandom);
    close_out();
  end
endmodule

bind lin_uart_ext_ctl lin_uart_ext_ctl_assertions i_lin_uart_ext_ctl_assertions (
  .aclk, .aresetn, .serial_out_pin, .frame_sout, .sck_oe, .sample_strobe,
  .soft_reset_pulse, .tx_irq, .cfg_ctrl, .cfg_ext);
